// ### hw/ffe_defines.vh
// Constants for the foreground field editor: screen geometry, cell layout,
// command codes and blink timing.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
`ifndef FFE_DEFINES_VH
`define FFE_DEFINES_VH

// Geometry: 4 lines of 8 columns, 32 cells
`define FFE_LINES       4
`define FFE_COLS        8
`define FFE_CELLS       32
`define FFE_AW          5
`define FFE_LAST_POS    5'h1F
// Cell layout: bit 7 marks a protected background cell
`define FFE_PROT_BIT    7
`define FFE_CELL_RST    8'h20
`define FFE_BLANK_FG    8'h20
// Command codes
`define FFE_CMD_NOP     3'h0
`define FFE_CMD_INSERT  3'h1
`define FFE_CMD_DELETE  3'h2
`define FFE_CMD_CLEAR   3'h3
`define FFE_CMD_TAB     3'h4
`define FFE_CMD_CURSOR  3'h5
`define FFE_CMD_LOAD    3'h6
// Blink timing
`define FFE_BLINK_NS    50
`define FFE_CLK_NS      10

`endif

// ### hw/ffe_editor.v
// Foreground field editor: refresh memory held in flip-flops, cursor, and
// single-cycle insert, delete, clear-foreground and tab commands.
// Assumes commands come from keyboard logic on the same clock, one per
// cycle at most, so no input synchronisers are needed.
`include "ffe_defines.vh"
`default_nettype none

module ffe_editor (
    // Clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // Command port
    input  wire         cmd_valid,
    input  wire [2:0]   cmd_code,
    input  wire [6:0]   cmd_char,
    input  wire [4:0]   cmd_addr,
    input  wire [7:0]   cmd_data,
    // Display read port
    input  wire [4:0]   rd_addr,
    output reg  [7:0]   rd_data_q,
    // Status
    output reg  [4:0]   cursor_q,
    output reg          blink_q,
    output reg          done_q
);

    // Cell layout: bit 7 set marks protected background text, bits 6:0
    // hold the character. A field is a run of foreground cells on one
    // line, ending before the next background cell or at the line end.
    // Every command completes in the cycle it is taken; there is no
    // busy state, so the keyboard side may issue one per cycle.

    // Blink length in clock cycles, rounded up from the time figure
    localparam integer BLINK_CYC =
        (`FFE_BLINK_NS + `FFE_CLK_NS - 1) / `FFE_CLK_NS;
    localparam [3:0] BLINK_LOAD = BLINK_CYC[3:0];

    // Refresh memory, one byte per cell, cell n at bits 8n+7..8n
    reg  [8*`FFE_CELLS-1:0] mem_q;
    wire [8*`FFE_CELLS-1:0] mem_d;
    // Protect flag of every cell, and where each foreground field begins
    wire [`FFE_CELLS-1:0]   prot;
    wire [`FFE_CELLS-1:0]   fstart;
    // Blink timer and search results
    reg  [3:0]              blink_cnt_q;
    reg  [2:0]              fend;
    reg                     fstop;
    reg  [4:0]              tab_tgt;
    reg  [5:0]              tab_start;
    integer                 j;
    integer                 p;

    // Cursor position split into line and column
    wire [1:0] cur_line = cursor_q[4:3];
    wire [2:0] cur_col  = cursor_q[2:0];
    wire       cur_prot = prot[cursor_q];

    // Raw command decode; only one command is presented per cycle
    wire       is_ins   = cmd_valid && (cmd_code == `FFE_CMD_INSERT);
    wire       is_del   = cmd_valid && (cmd_code == `FFE_CMD_DELETE);
    wire       is_tab   = cmd_valid && (cmd_code == `FFE_CMD_TAB);
    wire       is_cur   = cmd_valid && (cmd_code == `FFE_CMD_CURSOR);
    wire       is_any   = cmd_valid && (cmd_code != `FFE_CMD_NOP);
    wire       do_clr   = cmd_valid && (cmd_code == `FFE_CMD_CLEAR);
    wire       do_load  = cmd_valid && (cmd_code == `FFE_CMD_LOAD);

    // Edits act only on a foreground cell. On background they are
    // refused outright, so a stray key can never disturb protected text;
    // the user sees a blink instead of a silent no-operation.
    wire       do_ins   = is_ins && !cur_prot;
    wire       do_del   = is_del && !cur_prot;
    wire       refuse   = (is_ins || is_del) && cur_prot;

    // Field end: last foreground column before the next protected cell.
    // Searching only the cursor line keeps other lines out of reach.
    always @* begin
        fend  = cur_col;
        fstop = 1'b0;
        for (j = 0; j < `FFE_COLS; j = j + 1) begin
            if (j > cur_col && !fstop) begin
                if (prot[{cur_line, j[2:0]}])
                    fstop = 1'b1;
                else
                    fend = j[2:0];
            end
        end
    end

    // Tab target: lowest field start at or after the search start. Home
    // searches from itself, any other cell from the one after it; with no
    // field left the cursor parks on the last cell of the screen.
    always @* begin
        if (cursor_q == 5'h00)
            tab_start = 6'h00;
        else
            tab_start = {1'b0, cursor_q} + 6'h01;
        tab_tgt = `FFE_LAST_POS;
        for (p = `FFE_CELLS - 1; p >= 0; p = p - 1) begin
            if (p >= tab_start && fstart[p])
                tab_tgt = p[4:0];
        end
    end

    // Per-cell flags and next value; only the cursor line ever shifts
    genvar i;
    generate
        for (i = 0; i < `FFE_CELLS; i = i + 1) begin : g_cell
            // Place of this cell; neighbours are clamped at the ends of
            // memory, and the clamped values are never selected
            localparam integer IN   = i;
            localparam integer LN   = i / `FFE_COLS;
            localparam integer CN   = i % `FFE_COLS;
            localparam integer PREV = (i == 0) ? 0 : i - 1;
            localparam integer NEXT = (i == `FFE_CELLS - 1) ? i : i + 1;
            localparam [4:0]   IDX  = IN[4:0];
            localparam [1:0]   LL   = LN[1:0];
            localparam [2:0]   CC   = CN[2:0];
            wire [7:0] cur      = mem_q[8*i +: 8];
            wire [7:0] left_nb  = mem_q[8*PREV +: 8];
            wire [7:0] right_nb = mem_q[8*NEXT +: 8];
            wire       line     = (LL == cur_line);
            wire       at_cur   = line && (CC == cur_col);
            wire       ins_sh   = line && (CC > cur_col) && (CC <= fend);
            wire       del_sh   = line && (CC >= cur_col) && (CC < fend);
            wire       del_end  = line && (CC == fend);
            reg  [7:0] nxt;
            // Protect and field-start flags for the searches above
            assign prot[i] = cur[`FFE_PROT_BIT];
            if (CN == 0) begin : g_first
                assign fstart[i] = !cur[`FFE_PROT_BIT];
            end else begin : g_rest
                assign fstart[i] = !cur[`FFE_PROT_BIT]
                                   && left_nb[`FFE_PROT_BIT];
            end
            // Load wins over edits; it only serves to set up the screen
            always @* begin
                nxt = cur;
                if (do_load && (cmd_addr == IDX))
                    nxt = cmd_data;
                else if (do_ins && at_cur)
                    nxt = {1'b0, cmd_char};
                else if (do_ins && ins_sh)
                    nxt = left_nb;
                else if (do_del && del_sh)
                    nxt = right_nb;
                else if (do_del && del_end)
                    nxt = `FFE_BLANK_FG;
                else if (do_clr && !cur[`FFE_PROT_BIT])
                    nxt = `FFE_BLANK_FG;
            end
            assign mem_d[8*i +: 8] = nxt;
        end
    endgenerate

    // Memory: every cell takes its next value on each edge, so a refused
    // edit just leaves each next value equal to the old one
    always @(posedge clk) begin
        if (sys_rst) begin
            mem_q <= {`FFE_CELLS{`FFE_CELL_RST}};
        end else begin
            mem_q <= mem_d;
        end
    end

    // Read port: shows memory as it stood before this edge's update,
    // so a read issued with an edit returns the old contents
    always @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= mem_q[8*rd_addr +: 8];
        end
    end

    // Cursor: only tab and set-cursor move it. Insert and delete leave
    // it in place, so repeated keys keep working on the same cell.
    always @(posedge clk) begin
        if (sys_rst) begin
            cursor_q <= 5'h00;
        end else if (is_tab) begin
            cursor_q <= tab_tgt;
        end else if (is_cur) begin
            cursor_q <= cmd_addr;
        end
    end

    // Blink timer: reloaded by every refusal, so a key held on background
    // keeps the screen flashing rather than queueing flashes
    always @(posedge clk) begin
        if (sys_rst) begin
            blink_cnt_q <= 4'h0;
        end else if (refuse) begin
            blink_cnt_q <= BLINK_LOAD;
        end else if (blink_cnt_q != 4'h0) begin
            blink_cnt_q <= blink_cnt_q - 4'h1;
        end
    end

    // Blink output rises with the refusal itself and falls as the timer
    // reaches its last count, giving exactly BLINK_CYC high cycles
    always @(posedge clk) begin
        if (sys_rst) begin
            blink_q <= 1'b0;
        end else begin
            blink_q <= refuse || (blink_cnt_q > 4'h1);
        end
    end

    // Done pulse: one cycle after any command but no-operation. Refused
    // edits pulse too, so the keyboard side never waits on a lost reply.
    always @(posedge clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= is_any;
        end
    end

endmodule // ffe_editor

`default_nettype wire

// ### tb/ffe_editor_checker.sv
// Port checker for ffe_editor; bound below, sees its ports only.
`include "ffe_defines.vh"
`default_nettype none
module ffe_editor_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Command port
    input wire logic       cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [4:0] cmd_addr,
    // Status outputs
    input wire logic [4:0] cursor_q,
    input wire logic       blink_q,
    input wire logic       done_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Decoded commands
    wire ins = cmd_valid && cmd_code == `FFE_CMD_INSERT;
    wire del = cmd_valid && cmd_code == `FFE_CMD_DELETE;
    wire clr = cmd_valid && cmd_code == `FFE_CMD_CLEAR;
    wire setc = cmd_valid && cmd_code == `FFE_CMD_CURSOR;
    wire edit = ins || del;
    AST_INS_CUR: assert property (ins |=> $stable(cursor_q))
        else $error("insert moved cursor");
    AST_DEL_CUR: assert property (del |=> $stable(cursor_q))
        else $error("delete moved cursor");
    AST_BLINK_LEN: assert property ($rose(blink_q) |-> blink_q[*5])
        else $error("blink too short");
    AST_BLINK_WHY: assert property ($rose(blink_q) |-> $past(edit))
        else $error("blink without edit");
    AST_CLR_QUIET: assert property (clr && !blink_q |=> !blink_q)
        else $error("clear blinked");
    AST_DONE: assert property (cmd_valid && cmd_code != 3'h0 |=> done_q)
        else $error("no done pulse");
    AST_DONE_WHY: assert property (done_q |-> $past(cmd_valid))
        else $error("done without command");
    AST_SET_CUR: assert property (setc |=> cursor_q == $past(cmd_addr))
        else $error("cursor not set");
endmodule // ffe_editor_checker
bind ffe_editor ffe_editor_checker u_chk (.clk, .sys_rst, .cmd_valid,
    .blink_q, .done_q, .cmd_code, .cmd_addr, .cursor_q);
`default_nettype wire

// ### tb/ffe_editor_tb_top.sv
// Bench for ffe_editor; the keyboard model issues every command.
`include "ffe_defines.vh"
`default_nettype none
module ffe_editor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0, sys_rst = 1, cmd_valid, blink_q, done_q;
    logic [2:0] cmd_code;
    logic [6:0] cmd_char;
    logic [4:0] cmd_addr, cursor_q, rd_addr = 0;
    logic [7:0] cmd_data, rd_data_q, m [32];
    int         fails = 0, samples_checked = 0;
    ffe_kbd_model u_kbd (.clk, .cmd_valid, .cmd_code, .cmd_char, .cmd_addr,
        .cmd_data);
    ffe_editor u_dut (.clk, .sys_rst, .cmd_valid, .cmd_code, .cmd_char,
        .cmd_addr, .cmd_data, .rd_addr, .rd_data_q, .cursor_q, .blink_q,
        .done_q);
    initial forever #5 clk = ~clk;
    // Whole run needs about 354 cycles; this is far past it
    initial begin
        #100000 fails++;
        test_done();
    end
    task automatic chk(logic [7:0] g, e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("checked %0d failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Read data lags the address by one edge
    task automatic mem_ok();
        for (int i = 0; i < `FFE_CELLS; i++) begin
            @(negedge clk) rd_addr = i[4:0];
            @(negedge clk) chk(rd_data_q, m[i]);
        end
    endtask
    // Cursor at home sits on a protected cell; both edits must be refused
    task automatic test_refuse();
        u_kbd.put(`FFE_CMD_DELETE);
        chk(blink_q, 8'h01);
        repeat (6) @(negedge clk);
        chk(blink_q, 8'h00);
        u_kbd.put(`FFE_CMD_INSERT, 7'h58);
        chk(blink_q, 8'h01);
        mem_ok();
        u_kbd.put(`FFE_CMD_CURSOR);
        u_kbd.put(`FFE_CMD_TAB);
        chk(cursor_q, 8'h02);
        $display("refusal and tab test ended");
    endtask
    // Field of line 0 is cells 2..5; overflow drops, the tail fills blank
    task automatic test_edit();
        for (int k = 0; k < 3; k++) begin
            u_kbd.put(`FFE_CMD_INSERT, 7'h58 + k[6:0]);
            for (int n = 5; n > 2; n--) m[n] = m[n-1];
            m[2] = {1'b0, 7'h58 + k[6:0]};
            chk(cursor_q, 8'h02);
            chk(done_q, 8'h01);
        end
        mem_ok();
        for (int k = 0; k < 3; k++) begin
            u_kbd.put(`FFE_CMD_DELETE);
            for (int n = 2; n < 5; n++) m[n] = m[n+1];
            m[5] = 8'h20;
            chk(cursor_q, 8'h02);
        end
        mem_ok();
        u_kbd.put(`FFE_CMD_CLEAR);
        foreach (m[i]) if (!m[i][7]) m[i] = 8'h20;
        mem_ok();
        $display("edit and clear test ended");
    endtask
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 0;
        // Columns 0, 1 and 6 of each line are protected background
        for (int i = 0; i < `FFE_CELLS; i++) begin
            m[i] = {(i[2:1] == 2'h0) || (i[2:0] == 3'h6), 2'h2, i[4:0]};
            u_kbd.put(`FFE_CMD_LOAD, 0, i[4:0], m[i]);
        end
        test_refuse();
        test_edit();
        test_done();
    end
endmodule // ffe_editor_tb_top
`default_nettype wire

// ### tb/ffe_kbd_model.sv
// Keyboard model: one command of any code per call; editor samples on rising edge.
`default_nettype none
module ffe_kbd_model (
    // Clock and command port
    input  wire logic       clk,
    output var  logic       cmd_valid,
    output var  logic [2:0] cmd_code,
    output var  logic [6:0] cmd_char,
    output var  logic [4:0] cmd_addr,
    output var  logic [7:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {cmd_valid, cmd_code, cmd_char, cmd_addr, cmd_data} = '0;
    // Idle fields carry inverted junk so stale data never looks valid
    task automatic put(logic [2:0] c, logic [6:0] h = 0, logic [4:0] a = 0,
                       logic [7:0] d = 0);
        @(negedge clk) cmd_valid = 1'b1;
        {cmd_code, cmd_char, cmd_addr, cmd_data} = {c, h, a, d};
        @(negedge clk) cmd_valid = 1'b0;
        {cmd_code, cmd_char, cmd_addr, cmd_data} = ~{c, h, a, d};
    endtask
endmodule // ffe_kbd_model
`default_nettype wire
